/* File: quasi_bidir_ports.sv */
// four port latches with drivers and read paths, ports 1-3 quasi-bidirectional
// Overview of operation
// - four ports: latch, driver, input buffer each
// - bus: port 0 low address, port 2 high
// - write strobe loads bus into port latch
// - read latch or pin, chosen by instruction
// - each line independently input or output
// - output pin follows written latch bit
// - latch one turns off pull-down driver
// - alternate function needs latch one on 1,3
// - bus cycle drives ports 0,2 from address/data
// - port 0 pulls up only on bus ones
// - read-modify-write reads the latch
// - bit writes rewrite whole latch byte
// - ports 1,3 pulled up, port 2 outside bus cycles; read one undriven
// - port 0 input floats, no pull-up
// - reset sets every latch bit to one
// - writing one returns pin to input
// - port 1 timer two and counter-array functions
// - port 3 serial, interrupt, timer inputs
// - port 3 bits 6,7 write/read strobes
// - bus cycle fills port 0 latch with ones
// - port 2 latch kept, shown when free
// - latch updates at end, pins next instruction
`timescale 1ns/10ps
`default_nettype none
module quasi_bidir_ports #(
   parameter int unsigned PORT_W = port_pkg::PORT_W
) (
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   // cpu register access
   input  wire logic [1:0]        port_sel_i,
   input  wire logic              write_strobe_i,
   input  wire logic [PORT_W-1:0] write_data_i,
   input  wire logic              read_strobe_i,
   input  wire logic              read_latch_i,
   input  wire logic              bit_write_i,
   input  wire logic [2:0]        bit_index_i,
   input  wire port_pkg::bit_op_e bit_op_i,
   input  wire logic              carry_i,
   input  wire logic              instr_boundary_i,
   output logic [PORT_W-1:0]      read_data_o,
   output logic                   read_valid_o,
   // external bus control
   input  wire logic              page_mode_i,
   input  wire logic              bus_cycle_i,
   input  wire logic              bus_addr_phase_i,
   input  wire logic              bus_data_out_i,
   input  wire logic [PORT_W-1:0] low_addr_data_lines_i,
   input  wire logic [PORT_W-1:0] upper_address_lines_i,
   input  wire logic [PORT_W-1:0] bus_wdata_i,
   output logic [PORT_W-1:0]      bus_rdata_o,
   // port 1 alternate functions
   input  wire logic              timer_two_clock_out_i,
   input  wire logic [4:0]        counter_array_out_i,
   output logic                   timer_two_clock_pin_o,
   output logic                   timer_two_ext_input_o,
   output logic                   counter_array_clock_input_o,
   output logic [4:0]             counter_array_module_io_o,
   // port 3 alternate functions
   input  wire logic              serial_txd_i,
   input  wire logic              ext_write_strobe_n_i,
   input  wire logic              ext_read_strobe_or_addr_bit16_i,
   output logic                   serial_rxd_o,
   output logic                   ext_interrupt_zero_input_o,
   output logic                   ext_interrupt_one_input_o,
   output logic                   timer_zero_count_input_o,
   output logic                   timer_one_count_input_o,
   // port pins
   input  wire logic [PORT_W-1:0] p0_pin_i,
   input  wire logic [PORT_W-1:0] p1_pin_i,
   input  wire logic [PORT_W-1:0] p2_pin_i,
   input  wire logic [PORT_W-1:0] p3_pin_i,
   output logic [PORT_W-1:0]      p0_pin_o,
   output logic [PORT_W-1:0]      p0_pin_oe_o,
   output logic [PORT_W-1:0]      p1_pin_o,
   output logic [PORT_W-1:0]      p1_pin_oe_o,
   output logic [PORT_W-1:0]      p2_pin_o,
   output logic [PORT_W-1:0]      p2_pin_oe_o,
   output logic [PORT_W-1:0]      p3_pin_o,
   output logic [PORT_W-1:0]      p3_pin_oe_o,
   output logic [PORT_W-1:0]      p1_pullup_o,
   output logic [PORT_W-1:0]      p2_pullup_o,
   output logic [PORT_W-1:0]      p3_pullup_o
);

   ////////////////////////////////////////////////////////////////////////
   // latches

   logic [PORT_W-1:0] low_byte_bus_port_latch_reg;
   logic [PORT_W-1:0] peripheral_port_latch_reg;
   logic [PORT_W-1:0] high_byte_bus_port_latch_reg;
   logic [PORT_W-1:0] control_pins_port_latch_reg;
   logic [PORT_W-1:0] latch_sel;
   logic [PORT_W-1:0] pin_sel;
   logic [PORT_W-1:0] bit_mask;
   logic              bit_value;
   logic [PORT_W-1:0] bit_write_byte;
   logic [PORT_W-1:0] latch_next;
   logic              latch_load;

   pin_sync_if pins ();
   logic [PORT_W-1:0] p0_sync;
   logic [PORT_W-1:0] p1_sync;
   logic [PORT_W-1:0] p2_sync;
   logic [PORT_W-1:0] p3_sync;
   assign pins.raw = {p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i};
   pin_sync #(
      .WIDTH (4 * PORT_W)
   ) u_pin_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .bus     (pins)
   );
   assign p0_sync = pins.synced[PORT_W-1:0];
   assign p1_sync = pins.synced[2*PORT_W-1:PORT_W];
   assign p2_sync = pins.synced[3*PORT_W-1:2*PORT_W];
   assign p3_sync = pins.synced[4*PORT_W-1:3*PORT_W];

   assign latch_sel = (port_sel_i == port_pkg::PORT0_SEL) ? low_byte_bus_port_latch_reg :
                      (port_sel_i == port_pkg::PORT1_SEL) ? peripheral_port_latch_reg :
                      (port_sel_i == port_pkg::PORT2_SEL) ? high_byte_bus_port_latch_reg :
                                                            control_pins_port_latch_reg;
   assign pin_sel   = (port_sel_i == port_pkg::PORT0_SEL) ? p0_sync :
                      (port_sel_i == port_pkg::PORT1_SEL) ? p1_sync :
                      (port_sel_i == port_pkg::PORT2_SEL) ? p2_sync :
                                                            p3_sync;

   assign bit_mask = PORT_W'(1) << bit_index_i;
   always_comb begin
      case (bit_op_i)
         port_pkg::BIT_CLEAR: bit_value = 1'b0;
         port_pkg::BIT_SET:   bit_value = 1'b1;
         port_pkg::BIT_CARRY: bit_value = carry_i;
         default:             bit_value = ~|(latch_sel & bit_mask);
      endcase
   end
   assign bit_write_byte = bit_value ? (latch_sel | bit_mask) : (latch_sel & ~bit_mask);

   // byte or bit write into latch
   assign latch_load = write_strobe_i | bit_write_i;
   assign latch_next = bit_write_i ? bit_write_byte : write_data_i;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_byte_bus_port_latch_reg <= port_pkg::LATCH_RESET;
      end else if (bus_cycle_i) begin
         low_byte_bus_port_latch_reg <= port_pkg::BUS_CYCLE_FILL;
      end else if (latch_load && port_sel_i == port_pkg::PORT0_SEL) begin
         low_byte_bus_port_latch_reg <= latch_next;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         peripheral_port_latch_reg    <= port_pkg::LATCH_RESET;
         high_byte_bus_port_latch_reg <= port_pkg::LATCH_RESET;
         control_pins_port_latch_reg  <= port_pkg::LATCH_RESET;
      end else if (latch_load) begin
         // port 2 latch untouched by bus
         if (port_sel_i == port_pkg::PORT1_SEL) begin
            peripheral_port_latch_reg <= latch_next;
         end else if (port_sel_i == port_pkg::PORT2_SEL) begin
            high_byte_bus_port_latch_reg <= latch_next;
         end else if (port_sel_i == port_pkg::PORT3_SEL) begin
            control_pins_port_latch_reg <= latch_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read paths

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         read_data_o  <= '0;
         read_valid_o <= 1'b0;
      end else begin
         read_valid_o <= read_strobe_i;
         if (read_strobe_i) begin
            read_data_o <= read_latch_i ? latch_sel : pin_sel;
         end
      end
   end

   // external read data from the multiplexed port
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_rdata_o <= '0;
      end else begin
         bus_rdata_o <= page_mode_i ? p2_sync : p0_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // driver staging

   logic [PORT_W-1:0] p0_drv_reg;
   logic [PORT_W-1:0] p1_drv_reg;
   logic [PORT_W-1:0] p2_drv_reg;
   logic [PORT_W-1:0] p3_drv_reg;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p1_drv_reg <= port_pkg::LATCH_RESET;
         p2_drv_reg <= port_pkg::LATCH_RESET;
         p3_drv_reg <= port_pkg::LATCH_RESET;
      end else if (instr_boundary_i) begin
         p1_drv_reg <= peripheral_port_latch_reg;
         p2_drv_reg <= high_byte_bus_port_latch_reg;
         p3_drv_reg <= control_pins_port_latch_reg;
      end
   end

   // bus fill also releases port 0 drivers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p0_drv_reg <= port_pkg::LATCH_RESET;
      end else if (bus_cycle_i) begin
         p0_drv_reg <= port_pkg::BUS_CYCLE_FILL;
      end else if (instr_boundary_i) begin
         p0_drv_reg <= low_byte_bus_port_latch_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers

   logic [PORT_W-1:0] p1_alt;
   logic [PORT_W-1:0] p3_alt;
   logic [PORT_W-1:0] p1_level;
   logic [PORT_W-1:0] p3_level;
   logic [PORT_W-1:0] p0_bus_val;
   logic [PORT_W-1:0] p2_bus_val;
   logic              p0_bus_drive;
   logic              p2_bus_drive;
   logic [PORT_W-1:0] p0_bus_oe;
   logic [PORT_W-1:0] p2_bus_oe;

   assign p1_alt = {counter_array_out_i, 2'h3, timer_two_clock_out_i};
   // strobes on bits 6 and 7
   assign p3_alt = {ext_read_strobe_or_addr_bit16_i, ext_write_strobe_n_i, 4'hF,
                    serial_txd_i, 1'b1};
   // alternate level gated by latch one
   assign p1_level = p1_drv_reg & p1_alt;
   assign p3_level = p3_drv_reg & p3_alt;

   // bus lines replace latch on drivers
   assign p0_bus_val   = (bus_addr_phase_i || page_mode_i) ? low_addr_data_lines_i
                                                          : bus_wdata_i;
   assign p2_bus_val   = (bus_addr_phase_i || !page_mode_i) ? upper_address_lines_i
                                                           : bus_wdata_i;
   assign p0_bus_drive = bus_cycle_i && (bus_addr_phase_i || page_mode_i || bus_data_out_i);
   assign p2_bus_drive = bus_cycle_i && (bus_addr_phase_i || !page_mode_i || bus_data_out_i);
   // bus data input leaves port floating
   assign p0_bus_oe    = {PORT_W{p0_bus_drive}};
   assign p2_bus_oe    = {PORT_W{p2_bus_drive}};

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p1_pin_o    <= port_pkg::LATCH_RESET;
         p1_pin_oe_o <= '0;
         p3_pin_o    <= port_pkg::LATCH_RESET;
         p3_pin_oe_o <= '0;
         p1_pullup_o <= '1;
         p2_pullup_o <= '1;
         p3_pullup_o <= '1;
      end else begin
         p1_pin_o    <= p1_level;
         p1_pin_oe_o <= ~p1_level;
         p3_pin_o    <= p3_level;
         p3_pin_oe_o <= ~p3_level;
         p1_pullup_o <= p1_level;
         p2_pullup_o <= bus_cycle_i ? '0 : p2_drv_reg;
         p3_pullup_o <= p3_level;
      end
   end

   // port 0 drives ones only on bus
   // port 2 shows latch when free
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         p0_pin_o    <= port_pkg::LATCH_RESET;
         p0_pin_oe_o <= '0;
         p2_pin_o    <= port_pkg::LATCH_RESET;
         p2_pin_oe_o <= '0;
      end else begin
         p0_pin_o    <= p0_bus_drive ? p0_bus_val : p0_drv_reg;
         p0_pin_oe_o <= bus_cycle_i ? p0_bus_oe : ~p0_drv_reg;
         p2_pin_o    <= p2_bus_drive ? p2_bus_val : p2_drv_reg;
         p2_pin_oe_o <= bus_cycle_i ? p2_bus_oe : ~p2_drv_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alternate inputs to peripherals

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_two_clock_pin_o       <= 1'b1;
         timer_two_ext_input_o       <= 1'b1;
         counter_array_clock_input_o <= 1'b1;
         counter_array_module_io_o   <= '1;
         serial_rxd_o                <= 1'b1;
         ext_interrupt_zero_input_o  <= 1'b1;
         ext_interrupt_one_input_o   <= 1'b1;
         timer_zero_count_input_o    <= 1'b1;
         timer_one_count_input_o     <= 1'b1;
      end else begin
         timer_two_clock_pin_o       <= p1_sync[0];
         timer_two_ext_input_o       <= p1_sync[1];
         counter_array_clock_input_o <= p1_sync[2];
         counter_array_module_io_o   <= p1_sync[7:3];
         serial_rxd_o                <= p3_sync[0];
         ext_interrupt_zero_input_o  <= p3_sync[2];
         ext_interrupt_one_input_o   <= p3_sync[3];
         timer_zero_count_input_o    <= p3_sync[4];
         timer_one_count_input_o     <= p3_sync[5];
      end
   end

endmodule : quasi_bidir_ports
`default_nettype wire

/* File: port_pkg.sv */
// shared constants for the four-port latch block
package port_pkg;
   localparam int unsigned PORT_W    = 8;
   localparam int unsigned NUM_PORTS = 4;
   localparam logic [1:0] PORT0_SEL  = 2'h0;
   localparam logic [1:0] PORT1_SEL  = 2'h1;
   localparam logic [1:0] PORT2_SEL  = 2'h2;
   localparam logic [1:0] PORT3_SEL  = 2'h3;
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   localparam logic [7:0] BUS_CYCLE_FILL = 8'hFF;
   // port 3 bit positions of the memory strobes
   localparam int unsigned P3_WRITE_BIT = 6;
   localparam int unsigned P3_READ_BIT  = 7;
   // bit operation codes for single-bit writes
   typedef enum logic [1:0] {
      BIT_CLEAR,
      BIT_SET,
      BIT_CARRY,
      BIT_COMPL
   } bit_op_e;
endpackage : port_pkg

/* File: pin_sync_if.sv */
// carrier between the top and the pin synchroniser
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if;
   logic [31:0] raw;
   logic [31:0] synced;
   modport src (output raw, input synced);
   modport snk (input raw, output synced);
endinterface : pin_sync_if
`default_nettype wire

/* File: pin_sync.sv */
// two-stage synchroniser for all port pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int unsigned WIDTH = 32
) (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // pins
   pin_sync_if.snk   bus
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage1_reg <= '1;
         stage2_reg <= '1;
      end else begin
         stage1_reg <= bus.raw[WIDTH-1:0];
         stage2_reg <= stage1_reg;
      end
   end
   assign bus.synced = stage2_reg;
endmodule : pin_sync
`default_nettype wire

/* File: qbp_props.sv */
// concurrent checks on the four-port latch block
`timescale 1ns/10ps
`default_nettype none
module qbp_props #(
   parameter int unsigned PORT_W = 8
) (
   // clock, reset and cpu side
   input wire logic              clock_i,
   input wire logic              rst_n_i,
   input wire logic              read_strobe_i,
   input wire logic              read_valid_o,
   input wire logic              instr_boundary_i,
   // bus side
   input wire logic              bus_cycle_i,
   input wire logic              bus_addr_phase_i,
   input wire logic [PORT_W-1:0] low_addr_data_lines_i,
   input wire logic [PORT_W-1:0] upper_address_lines_i,
   // pins
   input wire logic [PORT_W-1:0] p0_pin_o,
   input wire logic [PORT_W-1:0] p0_pin_oe_o,
   input wire logic [PORT_W-1:0] p1_pin_o,
   input wire logic [PORT_W-1:0] p1_pin_oe_o,
   input wire logic [PORT_W-1:0] p2_pin_o,
   input wire logic [PORT_W-1:0] p3_pin_o,
   input wire logic [PORT_W-1:0] p3_pin_oe_o,
   input wire logic [PORT_W-1:0] p3_pin_i,
   input wire logic              ext_interrupt_zero_input_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   chk_reset_ones:
      assert property ($rose(rst_n_i) |-> p1_pin_o == '1 && p3_pin_oe_o == '0)
      else $error("pins not released after reset");
   chk_read_answer:
      assert property (read_strobe_i |=> read_valid_o) else $error("read not answered");
   chk_valid_cause:
      assert property (read_valid_o |-> $past(read_strobe_i)) else $error("stray read valid");
   chk_quasi_drive:
      assert property (p1_pin_oe_o == ~p1_pin_o && p3_pin_oe_o == ~p3_pin_o)
      else $error("quasi port drives a one");
   chk_p0_open_drain:
      assert property (!$past(bus_cycle_i) |-> (p0_pin_o & p0_pin_oe_o) == '0)
      else $error("port 0 drives one outside bus");
   chk_bus_addr_out:
      assert property ($past(bus_cycle_i && bus_addr_phase_i) |->
         p0_pin_o == $past(low_addr_data_lines_i) && p2_pin_o == $past(upper_address_lines_i))
      else $error("address bytes not on ports");
   chk_alt_sync_delay:
      assert property ($stable(p3_pin_i[2]) [*4] |-> ext_interrupt_zero_input_o == p3_pin_i[2])
      else $error("alternate input not following pin");
   chk_pin_after_bnd:
      assert property ($changed(p2_pin_o) && !$past(bus_cycle_i) && !$past(bus_cycle_i, 2)
         |-> $past(instr_boundary_i, 2))
      else $error("port 2 pins moved without boundary");
endmodule : qbp_props
bind quasi_bidir_ports qbp_props #(.PORT_W(PORT_W)) u_props (.clock_i, .rst_n_i,
   .read_strobe_i, .read_valid_o, .instr_boundary_i, .bus_cycle_i, .bus_addr_phase_i,
   .low_addr_data_lines_i, .upper_address_lines_i, .p0_pin_o, .p0_pin_oe_o, .p1_pin_o,
   .p1_pin_oe_o, .p2_pin_o, .p3_pin_o, .p3_pin_oe_o, .p3_pin_i, .ext_interrupt_zero_input_o);
`default_nettype wire

/* File: pin_world.sv */
// external devices and wiring on the 32 port pins
`timescale 1ns/10ps
`default_nettype none
module pin_world (
   // clock
   input wire logic        clock_i,
   // device side, port 0 in the low byte
   input wire logic [31:0] drv_i,
   input wire logic [31:0] oe_i,
   input wire logic [31:0] pullup_i,
   // external devices
   input wire logic [31:0] ext_en_i,
   input wire logic [31:0] ext_val_i,
   output logic [31:0]     wire_o
);
   logic [31:0] flip_reg = 32'hA5A5A5A5;
   // undriven floating lines wander every cycle
   always @(posedge clock_i) flip_reg <= ~flip_reg;
   assign wire_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~oe_i & ~ext_en_i & (pullup_i | flip_reg));
endmodule : pin_world
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the four-port latch block
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic             clock_i, rst_n_i = 1'b0;
   logic [1:0]       port_sel_i = 2'h0;
   logic             write_strobe_i = 1'b0, read_strobe_i = 1'b0, read_latch_i = 1'b0;
   logic             bit_write_i = 1'b0, carry_i = 1'b0, instr_boundary_i = 1'b0;
   logic             page_mode_i = 1'b0, bus_cycle_i = 1'b0, bus_addr_phase_i = 1'b0;
   logic             bus_data_out_i = 1'b0, serial_txd_i = 1'b1, ext_write_strobe_n_i = 1'b1;
   logic [2:0]       bit_index_i = 3'h0;
   logic [7:0]       write_data_i = 8'h00, low_addr_data_lines_i = 8'h00, exp;
   logic [7:0]       upper_address_lines_i = 8'h00, bus_wdata_i = 8'h00;
   logic [31:0]      ext_en = 32'h0, ext_val = 32'h0, pw;
   logic [6:0]       alt_out = 7'h7F;
   wire  [10:0]      alt_in;
   port_pkg::bit_op_e bit_op_i = port_pkg::BIT_CLEAR;
   logic [7:0]       read_data_o, bus_rdata_o, p0_pin_o, p1_pin_o, p2_pin_o, p3_pin_o;
   logic [7:0]       p0_pin_oe_o, p1_pin_oe_o, p2_pin_oe_o, p3_pin_oe_o;
   logic [7:0]       p1_pullup_o, p2_pullup_o, p3_pullup_o;
   logic             read_valid_o, timer_two_clock_pin_o, ext_interrupt_zero_input_o;
   int               err_total = 0, total_checks = 0;
   quasi_bidir_ports u_dut (.clock_i, .rst_n_i, .port_sel_i, .write_strobe_i, .write_data_i,
      .read_strobe_i, .read_latch_i, .bit_write_i, .bit_index_i, .bit_op_i, .carry_i,
      .instr_boundary_i, .read_data_o, .read_valid_o, .page_mode_i, .bus_cycle_i,
      .bus_addr_phase_i, .bus_data_out_i, .low_addr_data_lines_i, .upper_address_lines_i,
      .bus_wdata_i, .bus_rdata_o, .timer_two_clock_out_i(alt_out[0]),
      .counter_array_out_i(alt_out[5:1]), .timer_two_clock_pin_o,
      .timer_two_ext_input_o(alt_in[4]), .counter_array_clock_input_o(alt_in[5]),
      .counter_array_module_io_o(alt_in[10:6]), .serial_txd_i, .ext_write_strobe_n_i,
      .ext_read_strobe_or_addr_bit16_i(alt_out[6]), .serial_rxd_o(alt_in[0]),
      .ext_interrupt_zero_input_o, .ext_interrupt_one_input_o(alt_in[1]),
      .timer_zero_count_input_o(alt_in[2]), .timer_one_count_input_o(alt_in[3]),
      .p0_pin_i(pw[7:0]), .p1_pin_i(pw[15:8]), .p2_pin_i(pw[23:16]), .p3_pin_i(pw[31:24]),
      .p0_pin_o, .p0_pin_oe_o, .p1_pin_o, .p1_pin_oe_o, .p2_pin_o, .p2_pin_oe_o, .p3_pin_o,
      .p3_pin_oe_o, .p1_pullup_o, .p2_pullup_o, .p3_pullup_o);
   pin_world u_world (.clock_i, .drv_i({p3_pin_o, p2_pin_o, p1_pin_o, p0_pin_o}),
      .oe_i({p3_pin_oe_o, p2_pin_oe_o, p1_pin_oe_o, p0_pin_oe_o}),
      .pullup_i({p3_pullup_o, p2_pullup_o, p1_pullup_o, 8'h00}), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .wire_o(pw));
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      total_checks++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask : chk
   task automatic wr(input logic [1:0] p, input logic [7:0] d);
      @(negedge clock_i); port_sel_i = p; write_data_i = d; write_strobe_i = 1'b1;
      @(negedge clock_i); write_strobe_i = 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] p, input logic l, input logic [7:0] e);
      @(negedge clock_i); port_sel_i = p; read_latch_i = l; read_strobe_i = 1'b1;
      @(negedge clock_i); read_strobe_i = 1'b0;
      chk(8'(read_valid_o), 8'h01);
      chk(read_data_o, e);
   endtask : rd
   task automatic bnd();
      @(negedge clock_i); instr_boundary_i = 1'b1;
      @(negedge clock_i); instr_boundary_i = 1'b0;
      @(negedge clock_i);
   endtask : bnd
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   initial begin
      repeat (5000) @(posedge clock_i);
      err_total++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clock_i);
      @(negedge clock_i); rst_n_i = 1'b1;
      for (int p = 0; p < 4; p++) rd(p[1:0], 1'b1, 8'hFF);
      $display("test reset done");
      wr(2'h1, 8'h5A); bnd();
      chk(p1_pin_o, 8'h5A);
      chk(p1_pin_oe_o, 8'hA5);
      chk(p1_pullup_o, 8'h5A);
      rd(2'h1, 1'b1, 8'h5A);
      wr(2'h1, 8'hFF); bnd();
      chk(p1_pin_oe_o, 8'h00);
      ext_en[15:8] = 8'h0F;
      repeat (4) @(negedge clock_i);
      rd(2'h1, 1'b0, 8'hF0);
      rd(2'h1, 1'b1, 8'hFF);
      chk(8'(timer_two_clock_pin_o), 8'h00);
      chk(8'(alt_in[10:4]), 8'h78);
      ext_en = 32'h0; $display("test latch and pin done");
      wr(2'h2, 8'hA5); exp = 8'hA5;
      for (int k = 0; k < 4; k++) begin
         @(negedge clock_i); port_sel_i = 2'h2; bit_index_i = 3'(2 * k + 1);
         bit_op_i = port_pkg::bit_op_e'(k[1:0]); bit_write_i = 1'b1;
         @(negedge clock_i); bit_write_i = 1'b0;
         exp[2*k+1] = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : (k == 2) ? carry_i : ~exp[2*k+1];
         rd(2'h2, 1'b1, exp);
      end
      wr(2'h0, 8'h00); bnd();
      chk(p0_pin_oe_o, 8'hFF);
      $display("test bit ops done");
      // ports 0 and 2 carry address and data while the bus runs
      @(negedge clock_i); bus_cycle_i = 1'b1; bus_addr_phase_i = 1'b1;
      low_addr_data_lines_i = 8'h12; upper_address_lines_i = 8'h34;
      @(negedge clock_i); chk(p0_pin_o, 8'h12);
      chk(p2_pin_o, 8'h34);
      chk(p2_pin_oe_o, 8'hFF);
      chk(p2_pullup_o, 8'h00);
      bus_addr_phase_i = 1'b0; bus_data_out_i = 1'b1; bus_wdata_i = 8'h5C;
      @(negedge clock_i); chk(p0_pin_o, 8'h5C);
      page_mode_i = 1'b1;
      @(negedge clock_i); chk(p2_pin_o, 8'h5C);
      page_mode_i = 1'b0; bus_data_out_i = 1'b0; ext_en[7:0] = 8'hFF; ext_val[7:0] = 8'hC3;
      repeat (4) @(negedge clock_i);
      chk(bus_rdata_o, 8'hC3);
      chk(p0_pin_oe_o, 8'h00);
      bus_cycle_i = 1'b0; ext_en = 32'h0;
      repeat (2) @(negedge clock_i);
      chk(p2_pin_o, exp);
      rd(2'h0, 1'b1, 8'hFF);
      rd(2'h2, 1'b1, exp);
      $display("test bus done");
      serial_txd_i = 1'b0; ext_write_strobe_n_i = 1'b0; alt_out = 7'h00;
      ext_en[31:24] = 8'h35; ext_val[31:24] = 8'h00;
      repeat (4) @(negedge clock_i);
      chk(8'(p3_pin_o[1]), 8'h00);
      chk(8'(p3_pin_o[6]), 8'h00);
      chk(8'(ext_interrupt_zero_input_o), 8'h00);
      chk(8'(alt_in[3:0]), 8'h02);
      chk(p3_pin_o, 8'h3D);
      chk(p3_pin_oe_o, 8'hC2);
      chk(p3_pullup_o, 8'h3D);
      chk(p1_pin_o, 8'h06);
      $display("test alternate done");
      close_out();
   end
endmodule : tb
`default_nettype wire
